// File: src/mid_id_eeprom.sv
// Emulated identification EEPROM: I2C slave, store and start-up scan
//
// Function
// - The store sits on the id I2C bus; a local write port also loads it.
// - At least 32 Kbit (4096 bytes) are addressable from the bus.
// - Three address-select inputs set the low slave address bits.
// - All selects low places the module store at 0x50 (0xA0 write).
// - All selects high places the carrier store at 0x57 (0xAE write).
// - The upper four slave address bits are fixed at 1010b.
// - Any larger store keeps the 32 Kbit command set unchanged.
// - After reset the whole content is read out as a buffered copy.
// - That copy feeds translation into IPMI FRU inventory records.
// - The emulation behaves on the bus as the identification EEPROM.
// - Only slave logic is used on the bus; it never masters it.
// - Carrier and module controllers talk IPMI over the IPMB port.
// - The store holds a unique id and the interface description.
// - The module controller offers an IPMB slave to the carrier side.
`timescale 1ns/100ps
module mid_id_eeprom #(
  parameter int DEPTH  = mid_pkg::MID_MEM_BYTES,
  parameter int ADDR_W = mid_pkg::MID_ADDR_W
) (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  input  wire logic                         scl_i,
  input  wire logic                         sda_i,
  output logic                              sda_o,
  output logic                              sda_oe_n,
  input  wire logic                         addr_select_bit2,
  input  wire logic                         addr_select_bit1,
  input  wire logic                         addr_select_bit0,
  input  wire logic                         loc_wr_valid,
  output logic                              loc_wr_ready,
  input  wire logic [ADDR_W-1:0]            loc_wr_addr,
  input  wire logic [mid_pkg::MID_DATA_W-1:0] loc_wr_data,
  output logic                              fru_valid,
  input  wire logic                         fru_ready,
  output logic      [ADDR_W-1:0]            fru_addr,
  output logic      [mid_pkg::MID_DATA_W-1:0] fru_data,
  output logic                              init_done
);
  import mid_pkg::*;

  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);

  logic [2:0]            sel_s1;
  logic [2:0]            sel;
  logic                  scl_s1;
  logic                  scl_s2;
  logic                  scl_q;
  logic                  sda_s1;
  logic                  sda_s2;
  logic                  sda_q;
  logic [6:0]            dev_addr;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  ev_start;
  logic                  ev_stop;
  mid_bus_st_t           st;
  mid_kind_t             kind;
  logic [3:0]            bit_cnt;
  logic [7:0]            shreg;
  logic [7:0]            txreg;
  logic                  rw;
  logic                  nack;
  logic [ADDR_W-1:0]     waddr;
  logic                  rx_end;
  logic                  dev_hit;
  logic                  tx_load;
  logic                  i2c_we;
  logic                  drive_low;
  mid_scan_st_t          sc_st;
  logic [ADDR_W-1:0]     scan_addr;
  logic                  mem_we;
  logic [ADDR_W-1:0]     mem_waddr;
  logic [MID_DATA_W-1:0] mem_wdata;
  logic [ADDR_W-1:0]     mem_raddr;
  logic [MID_DATA_W-1:0] mem_rdata;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q  <= 1'b1;
      sel_s1 <= MID_SEL_RST;
      sel    <= MID_SEL_RST;
    end else if (ce) begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_q  <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_q  <= sda_s2;
      sel_s1 <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
      sel    <= sel_s1;
    end
  end

  // ==========================================================
  // Bus events and addressing
  assign dev_addr = {MID_FIXED_UPPER, sel};
  assign scl_rise = scl_s2 & ~scl_q;
  assign scl_fall = ~scl_s2 & scl_q;
  assign ev_start = scl_s2 & scl_q & sda_q & ~sda_s2;
  assign ev_stop  = scl_s2 & scl_q & ~sda_q & sda_s2;
  assign rx_end   = (st == MID_ST_RX) && (bit_cnt == 4'd8) && scl_fall;
  assign dev_hit  = (shreg[7:1] == dev_addr);
  assign i2c_we   = rx_end && (kind == MID_K_DATA);
  assign tx_load  = scl_fall && !ev_stop &&
                    (((st == MID_ST_RX_ACK) && (kind == MID_K_DEV) && rw) ||
                     ((st == MID_ST_TX_ACK) && !nack));

  // Open-drain data: only ever pulls low, never drives high
  assign drive_low = (st == MID_ST_RX_ACK) ||
                     ((st == MID_ST_TX) && !txreg[7]);
  assign sda_o     = 1'b0;
  assign sda_oe_n  = ~drive_low;

  // ==========================================================
  // Slave protocol engine
  always_ff @(posedge clk) begin
    if (srst) begin
      st      <= MID_ST_IDLE;
      kind    <= MID_K_DEV;
      bit_cnt <= MID_CNT_RST;
      shreg   <= MID_BYTE_RST;
      txreg   <= MID_BYTE_RST;
      rw      <= 1'b0;
      nack    <= 1'b0;
    end else if (ce) begin
      // Bus is ignored until the start-up copy is complete
      if (!init_done || ev_stop) begin
        st <= MID_ST_IDLE;
      end else if (ev_start) begin
        st      <= MID_ST_RX;
        kind    <= MID_K_DEV;
        bit_cnt <= MID_CNT_RST;
      end else begin
        case (st)
          MID_ST_RX: begin
            if (scl_rise && bit_cnt != 4'd8) begin
              shreg   <= {shreg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'd1;
            end else if (rx_end) begin
              if (kind == MID_K_DEV && !dev_hit) begin
                st <= MID_ST_IDLE;
              end else begin
                st <= MID_ST_RX_ACK;
                if (kind == MID_K_DEV) begin
                  rw <= shreg[0];
                end
              end
            end
          end
          MID_ST_RX_ACK: begin
            if (tx_load) begin
              st      <= MID_ST_TX;
              txreg   <= mem_rdata;
              bit_cnt <= MID_CNT_RST;
            end else if (scl_fall) begin
              st      <= MID_ST_RX;
              bit_cnt <= MID_CNT_RST;
              case (kind)
                MID_K_DEV: kind <= MID_K_AHI;
                MID_K_AHI: kind <= MID_K_ALO;
                default:   kind <= MID_K_DATA;
              endcase
            end
          end
          MID_ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'd7) begin
                st <= MID_ST_TX_ACK;
              end else begin
                txreg   <= {txreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'd1;
              end
            end
          end
          MID_ST_TX_ACK: begin
            if (scl_rise) begin
              nack <= sda_s2;
            end else if (tx_load) begin
              st      <= MID_ST_TX;
              txreg   <= mem_rdata;
              bit_cnt <= MID_CNT_RST;
            end else if (scl_fall) begin
              st <= MID_ST_IDLE;
            end
          end
          default: st <= MID_ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Word address pointer
  // Upper bits of the high address byte are dropped, as on the base part
  always_ff @(posedge clk) begin
    if (srst) begin
      waddr <= MID_WADDR_RST;
    end else if (ce) begin
      if (rx_end && kind == MID_K_AHI) begin
        waddr[ADDR_W-1:8] <= shreg[ADDR_W-9:0];
      end else if (rx_end && kind == MID_K_ALO) begin
        waddr[7:0] <= shreg;
      end else if (i2c_we) begin
        // Writes wrap inside the page like the base part
        waddr[MID_PAGE_BITS-1:0] <=
          waddr[MID_PAGE_BITS-1:0] + MID_PAGE_BITS'(1);
      end else if (tx_load) begin
        waddr <= waddr + ADDR_W'(1);
      end
    end
  end

  // ==========================================================
  // Store; bus writes win over local loads
  assign loc_wr_ready = !i2c_we;
  assign mem_we       = i2c_we || loc_wr_valid;
  assign mem_waddr    = i2c_we ? waddr : loc_wr_addr;
  assign mem_wdata    = i2c_we ? shreg : loc_wr_data;
  assign mem_raddr    = init_done ? waddr : scan_addr;

  mid_id_mem #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W),
    .DATA_W (MID_DATA_W)
  ) u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ==========================================================
  // Start-up copy out to the FRU translator
  // Stalls on fru_ready so a slow consumer loses no byte
  assign fru_valid = (sc_st == MID_SC_OUT);

  always_ff @(posedge clk) begin
    if (srst) begin
      sc_st     <= MID_SC_RD;
      scan_addr <= MID_WADDR_RST;
      fru_addr  <= MID_WADDR_RST;
      fru_data  <= MID_BYTE_RST;
      init_done <= 1'b0;
    end else if (ce) begin
      case (sc_st)
        MID_SC_RD:   sc_st <= MID_SC_WAIT;
        MID_SC_WAIT: begin
          fru_data <= mem_rdata;
          fru_addr <= scan_addr;
          sc_st    <= MID_SC_OUT;
        end
        MID_SC_OUT: begin
          if (fru_ready) begin
            if (scan_addr == LAST_ADDR) begin
              sc_st     <= MID_SC_DONE;
              init_done <= 1'b1;
            end else begin
              scan_addr <= scan_addr + ADDR_W'(1);
              sc_st     <= MID_SC_RD;
            end
          end
        end
        default: sc_st <= MID_SC_DONE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_addr_byte_miss;
    ce && rx_end && kind == MID_K_DEV && !dev_hit;
  endsequence

  sequence s_byte_taken;
    ce && rx_end && !(kind == MID_K_DEV && !dev_hit) && !ev_stop;
  endsequence

  a_upper_fixed: assert property (dev_addr[6:3] == 4'hA)
    else $error("upper slave address bits not 1010b");

  a_module_addr: assert property (
    sel == 3'h0 |-> dev_addr == MID_MODULE_ADDR)
    else $error("module store not at 0x50");

  a_carrier_addr: assert property (
    sel == 3'h7 |-> dev_addr == MID_CARRIER_ADDR)
    else $error("carrier store not at 0x57");

  a_miss_no_ack: assert property (
    s_addr_byte_miss |=> st == MID_ST_IDLE && sda_oe_n)
    else $error("acked a foreign slave address");

  a_byte_acked: assert property (
    s_byte_taken |=> st == MID_ST_RX_ACK ##0 !sda_oe_n)
    else $error("received byte not acknowledged");

  a_slave_only: assert property (
    !sda_oe_n |-> st == MID_ST_RX_ACK || st == MID_ST_TX)
    else $error("data line pulled outside ack or read");

  a_read_incr: assert property (
    ce && tx_load && !rx_end |=> waddr == $past(waddr) + ADDR_W'(1))
    else $error("read pointer did not advance");

  a_write_page: assert property (
    ce && i2c_we |=> waddr[ADDR_W-1:MID_PAGE_BITS] ==
      $past(waddr[ADDR_W-1:MID_PAGE_BITS]))
    else $error("write crossed page boundary");

  a_scan_hold: assert property (
    fru_valid && !fru_ready |=> fru_valid && $stable(fru_data))
    else $error("copy byte dropped under stall");

  a_scan_end: assert property (
    ce && fru_valid && fru_ready && fru_addr == LAST_ADDR
      |=> init_done ##1 !fru_valid [*2])
    else $error("copy did not finish after last byte");

  a_busy_quiet: assert property (
    !init_done |-> st == MID_ST_IDLE && sda_oe_n)
    else $error("bus answered before copy complete");

endmodule

// File: src/mid_id_mem.sv
// Byte store with one write port and a registered read port
`timescale 1ns/100ps
module mid_id_mem #(
  parameter int DEPTH  = mid_pkg::MID_MEM_BYTES,
  parameter int ADDR_W = mid_pkg::MID_ADDR_W,
  parameter int DATA_W = mid_pkg::MID_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              ce,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata
);
  import mid_pkg::*;

  logic [DATA_W-1:0] mem [DEPTH];

  // ==========================================================
  // Storage; no reset so it maps onto block RAM
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule

// File: src/mid_pkg.sv
// Shared constants and types for the module identification store
package mid_pkg;

  // ==========================================================
  // Storage geometry
  localparam int MID_MEM_BYTES  = 4096;
  localparam int MID_ADDR_W     = 12;
  localparam int MID_DATA_W     = 8;
  localparam int MID_PAGE_BITS  = 5;
  localparam int MID_BYTE_BITS  = 8;

  // ==========================================================
  // Slave addressing
  localparam logic [3:0] MID_FIXED_UPPER = 4'hA;
  localparam logic [6:0] MID_MODULE_ADDR = 7'h50;
  localparam logic [6:0] MID_CARRIER_ADDR = 7'h57;

  // ==========================================================
  // Reset values
  localparam logic [MID_ADDR_W-1:0] MID_WADDR_RST = 12'h000;
  localparam logic [MID_DATA_W-1:0] MID_BYTE_RST  = 8'h00;
  localparam logic [3:0]            MID_CNT_RST   = 4'h0;
  localparam logic [2:0]            MID_SEL_RST   = 3'h0;

  // ==========================================================
  // State types
  typedef enum logic [2:0] {
    MID_ST_IDLE,
    MID_ST_RX,
    MID_ST_RX_ACK,
    MID_ST_TX,
    MID_ST_TX_ACK
  } mid_bus_st_t;

  typedef enum logic [1:0] {
    MID_K_DEV,
    MID_K_AHI,
    MID_K_ALO,
    MID_K_DATA
  } mid_kind_t;

  typedef enum logic [1:0] {
    MID_SC_RD,
    MID_SC_WAIT,
    MID_SC_OUT,
    MID_SC_DONE
  } mid_scan_st_t;

endpackage

// File: tb/mid_i2c_mst.sv
// I2C bus master model standing for the carrier side of the id bus
`timescale 1ns/100ps
module mid_i2c_mst #(
  parameter int Q = 12
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  // ==========================================================
  // Bus cycles, one quarter bit is Q clocks (about 830 kHz)
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end
  task automatic qw();
    repeat (Q) @(negedge clk);
  endtask
  // Serves as start and as repeated start
  task automatic start();
    pull = 1'b0;
    qw();
    scl = 1'b1;
    qw();
    pull = 1'b1;
    qw();
    scl = 1'b0;
    qw();
  endtask
  task automatic stop();
    pull = 1'b1;
    qw();
    scl = 1'b1;
    qw();
    pull = 1'b0;
    qw();
  endtask
  // Data moves only while clock is low; sampled mid high
  task automatic xbit(input logic b, output logic r);
    pull = ~b;
    qw();
    scl = 1'b1;
    qw();
    r = sda;
    qw();
    scl = 1'b0;
    qw();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(last, r);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the emulated identification store
`timescale 1ns/100ps
module tb_top;
  import mid_pkg::*;
  // ==========================================================
  // Clock, pins and models
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        ce   = 1'b1;
  logic [2:0]  sel  = 3'h0;
  logic        lv   = 1'b0;
  logic [11:0] la   = 12'h000;
  logic [7:0]  ld   = 8'h00;
  logic        fr   = 1'b1;
  logic        scl, pull, sda_o, oe_n, lrdy, fv, idone, ack;
  logic [11:0] fa, cur_a, a;
  logic [7:0]  fd;
  logic [6:0]  w;
  logic [7:0]  mem_exp [4096];
  int          seed = 32'h2256;
  int          mismatches = 0;
  int          checked = 0;
  int          k, n;
  // Pull-up: the wire is low when either party pulls
  wire         sda = ~(pull | ~oe_n);

  always #12.5 clk = ~clk;

  mid_id_eeprom dut_u (
    .clk(clk), .srst(srst), .ce(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(oe_n),
    .addr_select_bit2(sel[2]), .addr_select_bit1(sel[1]),
    .addr_select_bit0(sel[0]), .loc_wr_valid(lv),
    .loc_wr_ready(lrdy), .loc_wr_addr(la), .loc_wr_data(ld),
    .fru_valid(fv), .fru_ready(fr), .fru_addr(fa), .fru_data(fd),
    .init_done(idone)
  );
  mid_i2c_mst m (.clk(clk), .sda(sda), .scl(scl), .pull(pull));

  // ==========================================================
  // Checks, expectations and bus tasks
  task automatic stop_test();
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_v(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_v({11'h000, got}, {11'h000, exp});
  endtask
  function automatic logic [7:0] dev(input logic rw);
    return {MID_FIXED_UPPER, sel, rw};
  endfunction
  // Writes wrap inside a 32-byte page
  function automatic logic [11:0] nxt_w(input logic [11:0] x);
    return {x[11:5], x[4:0] + 5'h01};
  endfunction
  task automatic rst();
    srst = 1'b1;
    repeat (16) @(negedge clk);
    chk_b(idone, 1'b0);
    chk_b(oe_n, 1'b1);
    chk_b(sda_o, 1'b0);
    chk_b(lrdy, 1'b1);
    srst = 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    m.wbyte(b, ack);
    chk_b(ack, 1'b1);
  endtask
  task automatic probe(input logic [6:0] adr, input logic e);
    m.start();
    m.wbyte({adr, 1'b0}, ack);
    m.stop();
    chk_b(ack, e);
  endtask
  // Junk in the upper nibble of the high address byte is ignored
  task automatic i2c_wr(input logic [11:0] x, input int cnt);
    logic [7:0] d;
    m.start();
    send(dev(1'b0));
    send({4'($random(seed)), x[11:8]});
    send(x[7:0]);
    for (int i = 0; i < cnt; i++) begin
      d = 8'($random(seed));
      send(d);
      mem_exp[x] = d;
      x = nxt_w(x);
    end
    m.stop();
  endtask
  task automatic i2c_rd(input logic [11:0] x, input int cnt,
                        input logic cur);
    logic [7:0] d;
    if (!cur) begin
      m.start();
      send(dev(1'b0));
      send({4'h0, x[11:8]});
      send(x[7:0]);
    end
    m.start();
    send(dev(1'b1));
    for (int i = 0; i < cnt; i++) begin
      m.rbyte(i == cnt - 1, d);
      chk_v({4'h0, d}, {4'h0, mem_exp[x]});
      x = x + 12'h001;
    end
    cur_a = x;
    m.stop();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem_exp[i] = 8'($random(seed));
    end
    rst();
    for (int i = 0; i < 4096; i++) begin
      lv = 1'b1;
      la = 12'(i);
      ld = mem_exp[i];
      @(negedge clk);
      chk_b(lrdy, 1'b1);
    end
    lv = 1'b0;
    // Bus must stay deaf while the first copy is still running
    chk_b(idone, 1'b0);
    probe(7'h50, 1'b0);
    n = 0;
    while (idone !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        mismatches++;
        stop_test();
      end
    end
    // Second start-up copies the loaded content out, with stalls
    rst();
    k = 0;
    n = 0;
    while (k < 4096) begin
      @(negedge clk);
      fr = 1'($random(seed));
      if (fv === 1'b1 && fr) begin
        chk_v(fa, 12'(k));
        chk_v({4'h0, fd}, {4'h0, mem_exp[k]});
        k++;
        n = 0;
      end else begin
        n++;
        if (n > 40) begin
          mismatches++;
          stop_test();
        end
      end
    end
    @(negedge clk);
    chk_b(idone, 1'b1);
    chk_b(fv, 1'b0);
    for (int s = 0; s < 8; s++) begin
      sel = 3'(s);
      repeat (4) @(negedge clk);
      w = 7'($random(seed));
      if (w == {MID_FIXED_UPPER, sel}) begin
        w = ~w;
      end
      probe({MID_FIXED_UPPER, sel}, 1'b1);
      probe(w, 1'b0);
    end
    repeat (4) @(negedge clk);
    probe(7'h57, 1'b1);
    sel = 3'h0;
    repeat (4) @(negedge clk);
    probe(7'h50, 1'b1);
    i2c_wr(12'h03F, 2);
    i2c_rd(12'h03E, 3, 1'b0);
    i2c_rd(cur_a, 2, 1'b1);
    i2c_rd(12'h020, 1, 1'b0);
    a = 12'($random(seed));
    i2c_wr(a, 4);
    i2c_rd(a, 4, 1'b0);
    i2c_rd(12'hFFE, 4, 1'b0);
    stop_test();
  end
endmodule
